// ### spc_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Remote host on the register port
// ---------------------------------------------------------------
module spc_host_model (
	// Clock
	input  wire logic         ref_clk,
	// Register port
	output spc_pkg::spc_req_t req,
	input  wire logic [15:0]  rdData,
	input  wire logic         rdValid
);
	// Idle port until the first request
	initial begin
		req = '0;
	end

	// One write, driven after a falling edge and held across the taking edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		req.wrEn = 1'b1;
		req.addr = a;
		req.data = d;
		@(negedge ref_clk);
		req.wrEn = 1'b0;
		// Released lines show the inverse so stale data never looks valid
		req.addr = ~a;
		req.data = ~d;
	endtask

	// Whole 32-bit value: upper half to the high address, lower to the low
	task automatic wr32(input logic [3:0] hiAddr, input logic [31:0] v);
		wr(hiAddr, v[31:16]);
		wr(hiAddr + 4'h1, v[15:0]);
	endtask

	// One read; the answer is looked for in the few cycles after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d = 'x;
		@(negedge ref_clk);
		req.rdEn = 1'b1;
		req.addr = a;
		@(negedge ref_clk);
		req.rdEn = 1'b0;
		req.addr = ~a;
		for (i = 0; i < 4 && !ok; i++) begin
			if (rdValid === 1'b1) begin
				d = rdData;
				ok = 1'b1;
			end else begin
				@(negedge ref_clk);
			end
		end
	endtask

	// Fraction encoding used while the float bit is clear
	function automatic logic [31:0] q15(input real r);
		return 32'(longint'(r * 32768.0));
	endfunction
endmodule

// ### spc_params.svh
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
// How it works
// - All configuration and measurement registers are sixteen bits wide.
// - Command bit 1 at address 0x0 switches the output on or off.
// - Command bit 7 selects float or q15 fraction encoding for setpoints.
// - In fraction encoding the stored integer is the real value times 2^15.
// - Each 32-bit value uses a pair: upper half high, lower half low.
// - Voltage setpoint pair sits at write addresses 1 and 2.
// - Current setpoint pair sits at write addresses 3 and 4.
// - Power setpoint pair sits at write addresses 5 and 6.
// - Measured voltage pair reads at addresses 3 and 4.
// - Measured current pair reads at addresses 5 and 6.
// - Measured power pair reads at addresses 7 and 8.
// - Status at read address 0 gives output state, faults and regulation mode.
// - The command register holds twelve independent control bits.
// - Power stages are active only while output enable is set.
// - A rising fault-clear bit wipes fault history, then returns to zero.
// - Far sense off stops remote sensing and its dependent monitors.
// - Analog loop bit selects 4-20 mA current or 0-10 V voltage mode.
// - Impedance watch raises faults when output or cable impedance is bad.
// - Link watch raises a fault after a maximum idle period without traffic.
// - A setpoint above its limit is stored clamped to that limit.
// - In analog programming mode setpoints track analog inputs; writes ignored.

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define SPC_ADDR_CMD        4'h0
`define SPC_ADDR_VOLT_HI    4'h1
`define SPC_ADDR_VOLT_LO    4'h2
`define SPC_ADDR_AMP_HI     4'h3
`define SPC_ADDR_AMP_LO     4'h4
`define SPC_ADDR_WATT_HI    4'h5
`define SPC_ADDR_WATT_LO    4'h6
`define SPC_ADDR_STATUS     4'h0
`define SPC_ADDR_VMEAS_HI   4'h3
`define SPC_ADDR_VMEAS_LO   4'h4
`define SPC_ADDR_AMEAS_HI   4'h5
`define SPC_ADDR_AMEAS_LO   4'h6
`define SPC_ADDR_WMEAS_HI   4'h7
`define SPC_ADDR_WMEAS_LO   4'h8

// ---------------------------------------------------------------
// Command bit positions and reset value
// ---------------------------------------------------------------
`define SPC_CMD_FAULT_CLR   0
`define SPC_CMD_ON          1
`define SPC_CMD_FAR_SENSE   2
`define SPC_CMD_ANALOG_CUR  3
`define SPC_CMD_IMP_WATCH   4
`define SPC_CMD_LINK_WATCH  5
`define SPC_CMD_DIGITAL     6
`define SPC_CMD_FLOAT       7
`define SPC_CMD_BITS        12
`define SPC_CMD_MASK        16'h0fff
`define SPC_CMD_RESET       16'h0040

// ---------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------
`define SPC_ST_ON           0
`define SPC_ST_FAULT        1
`define SPC_ST_MODE_LSB     2
`define SPC_ST_HIST_LSB     4

// ---------------------------------------------------------------
// Limits and timing
// ---------------------------------------------------------------
`define SPC_Q15_FULL        32'h00008000
`define SPC_VOLT_MAX_FLT    32'h42700000
`define SPC_AMP_MAX_FLT     32'h43270000
`define SPC_WATT_MAX_FLT    32'h461c9000
`define SPC_REF_CLK_HZ      50000000
`define SPC_LINK_IDLE_MS    1000
`define SPC_LINK_IDLE_CYC   (`SPC_LINK_IDLE_MS * (`SPC_REF_CLK_HZ / 1000))
`endif

// ### spc_pkg.sv
package spc_pkg;
	// One 32-bit value per regulated quantity
	typedef struct packed {
		logic [31:0] volt;
		logic [31:0] amp;
		logic [31:0] watt;
	} spc_triple_t;

	// Fault history bits
	typedef struct packed {
		logic external;
		logic linkIdle;
		logic cableImp;
		logic outImp;
	} spc_faults_t;

	// Register port request
	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [3:0]  addr;
		logic [15:0] data;
	} spc_req_t;
endpackage

// ### spc_register_bank.sv
`timescale 1ns/10ps
`include "spc_params.svh"
module spc_register_bank #(
	parameter int unsigned IDLE_CYCLES = `SPC_LINK_IDLE_CYC,
	parameter logic [31:0] VOLT_MAX_Q15 = `SPC_Q15_FULL,
	parameter logic [31:0] AMP_MAX_Q15  = `SPC_Q15_FULL,
	parameter logic [31:0] WATT_MAX_Q15 = `SPC_Q15_FULL,
	parameter logic [31:0] VOLT_MAX_FLT = `SPC_VOLT_MAX_FLT,
	parameter logic [31:0] AMP_MAX_FLT  = `SPC_AMP_MAX_FLT,
	parameter logic [31:0] WATT_MAX_FLT = `SPC_WATT_MAX_FLT
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                nrst,
	// Register port
	input  wire spc_pkg::spc_req_t   req,
	output logic [15:0]              rdData,
	output logic                     rdValid,
	// Plant inputs
	input  wire spc_pkg::spc_triple_t analogTargets,
	input  wire spc_pkg::spc_triple_t measured,
	input  wire logic [1:0]          regMode,
	input  wire logic                outImpBad,
	input  wire logic                cableImpBad,
	input  wire logic                extFault,
	// Control outputs
	output spc_pkg::spc_triple_t     targets,
	output logic                     powerStageEn,
	output logic                     farSenseOff,
	output logic                     analogCurrentMode,
	output logic                     floatMode,
	output logic                     faultActive
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [15:0]          cmd_reg,     cmd_next;
	logic [2:0][15:0]     pendHi_reg,  pendHi_next;
	logic [2:0][15:0]     pendLo_reg,  pendLo_next;
	logic [2:0]           hiSeen_reg,  hiSeen_next;
	logic [2:0]           loSeen_reg,  loSeen_next;
	logic [2:0][31:0]     sp_reg,      sp_next;
	spc_pkg::spc_faults_t hist_reg,    hist_next;
	logic [31:0]          idle_reg,    idle_next;
	logic                 idleHit_reg, idleHit_next;
	logic                 fault_reg,   fault_next;
	logic [15:0]          rd_reg,      rd_next;
	logic                 rdv_reg,     rdv_next;

	logic [2:0][31:0]     maxQ15;
	logic [2:0][31:0]     maxFlt;
	logic [2:0][31:0]     analogIn;
	logic                 linkAct;
	logic                 clearPulse;

	assign maxQ15   = {WATT_MAX_Q15, AMP_MAX_Q15, VOLT_MAX_Q15};
	assign maxFlt   = {WATT_MAX_FLT, AMP_MAX_FLT, VOLT_MAX_FLT};
	assign analogIn = {analogTargets.watt, analogTargets.amp, analogTargets.volt};
	assign linkAct  = req.wrEn | req.rdEn;
	// Stored bit is one only for the cycle after a rising write
	assign clearPulse = cmd_reg[`SPC_CMD_FAULT_CLR];

	// Saturate to the limit in the active encoding
	function automatic logic [31:0] clampVal(input logic [31:0] v, input logic [31:0] mq,
		input logic [31:0] mf, input logic isFloat);
		logic [31:0] r;
		r = v;
		if (isFloat) begin
			// Positive floats order like unsigned integers; negatives are below any limit
			if (!v[31] && v > mf) begin
				r = mf;
			end
		end else if ($signed(v) > $signed(mq)) begin
			r = mq;
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Command register
	// ---------------------------------------------------------------
	always_comb begin
		cmd_next = cmd_reg;
		cmd_next[`SPC_CMD_FAULT_CLR] = 1'b0;
		if (req.wrEn && req.addr == `SPC_ADDR_CMD) begin
			cmd_next = req.data & `SPC_CMD_MASK;
			// Only a zero-to-one change fires the clear
			cmd_next[`SPC_CMD_FAULT_CLR] = req.data[`SPC_CMD_FAULT_CLR]
				& ~cmd_reg[`SPC_CMD_FAULT_CLR];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg <= `SPC_CMD_RESET;
		end else begin
			cmd_reg <= cmd_next;
		end
	end

	// ---------------------------------------------------------------
	// Setpoint pairs
	// ---------------------------------------------------------------
	// Halves wait in staging until both arrive, so the plant never sees a torn value
	always_comb begin
		logic [3:0]  hiAddr;
		logic [3:0]  loAddr;
		logic        wHi;
		logic        wLo;
		logic [15:0] h;
		logic [15:0] l;
		hiAddr      = 4'h0;
		loAddr      = 4'h0;
		wHi         = 1'b0;
		wLo         = 1'b0;
		h           = 16'h0000;
		l           = 16'h0000;
		pendHi_next = pendHi_reg;
		pendLo_next = pendLo_reg;
		hiSeen_next = hiSeen_reg;
		loSeen_next = loSeen_reg;
		sp_next     = sp_reg;
		for (int i = 0; i < 3; i++) begin
			hiAddr = `SPC_ADDR_VOLT_HI + 4'(2 * i);
			loAddr = `SPC_ADDR_VOLT_LO + 4'(2 * i);
			wHi    = req.wrEn && req.addr == hiAddr;
			wLo    = req.wrEn && req.addr == loAddr;
			h      = wHi ? req.data : pendHi_reg[i];
			l      = wLo ? req.data : pendLo_reg[i];
			if (!cmd_reg[`SPC_CMD_DIGITAL]) begin
				// Analog programming: registers follow the inputs
				sp_next[i]     = analogIn[i];
				hiSeen_next[i] = 1'b0;
				loSeen_next[i] = 1'b0;
			end else if ((hiSeen_reg[i] | wHi) && (loSeen_reg[i] | wLo)) begin
				sp_next[i] = clampVal({h, l}, maxQ15[i], maxFlt[i],
					cmd_reg[`SPC_CMD_FLOAT]);
				hiSeen_next[i] = 1'b0;
				loSeen_next[i] = 1'b0;
				pendHi_next[i] = h;
				pendLo_next[i] = l;
			end else begin
				pendHi_next[i] = h;
				pendLo_next[i] = l;
				hiSeen_next[i] = hiSeen_reg[i] | wHi;
				loSeen_next[i] = loSeen_reg[i] | wLo;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pendHi_reg <= '0;
			pendLo_reg <= '0;
			hiSeen_reg <= '0;
			loSeen_reg <= '0;
			sp_reg     <= '0;
		end else begin
			pendHi_reg <= pendHi_next;
			pendLo_reg <= pendLo_next;
			hiSeen_reg <= hiSeen_next;
			loSeen_reg <= loSeen_next;
			sp_reg     <= sp_next;
		end
	end

	// ---------------------------------------------------------------
	// Link watch and fault history
	// ---------------------------------------------------------------
	// Any access restarts the idle count; disabled watch holds it at zero
	always_comb begin
		idle_next    = idle_reg;
		idleHit_next = 1'b0;
		if (!cmd_reg[`SPC_CMD_LINK_WATCH] || linkAct) begin
			idle_next = 32'h00000000;
		end else if (idle_reg >= IDLE_CYCLES - 1) begin
			idleHit_next = 1'b1;
		end else begin
			idle_next = idle_reg + 32'h00000001;
		end
	end

	// New events win over a clear in the same cycle
	always_comb begin
		hist_next = hist_reg;
		if (clearPulse) begin
			hist_next = '0;
		end
		if (cmd_reg[`SPC_CMD_IMP_WATCH] && outImpBad) begin
			hist_next.outImp = 1'b1;
		end
		if (cmd_reg[`SPC_CMD_IMP_WATCH] && !cmd_reg[`SPC_CMD_FAR_SENSE] && cableImpBad) begin
			hist_next.cableImp = 1'b1;
		end
		if (idleHit_reg) begin
			hist_next.linkIdle = 1'b1;
		end
		if (extFault) begin
			hist_next.external = 1'b1;
		end
		// Fault pin follows the next history, so it rises with the history bit itself
		fault_next = |hist_next;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			idle_reg    <= 32'h00000000;
			idleHit_reg <= 1'b0;
			hist_reg    <= '0;
			fault_reg   <= 1'b0;
		end else begin
			idle_reg    <= idle_next;
			idleHit_reg <= idleHit_next;
			hist_reg    <= hist_next;
			fault_reg   <= fault_next;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Read space is separate from write space; unmapped reads return zero
	always_comb begin
		rd_next  = 16'h0000;
		rdv_next = req.rdEn;
		if (req.rdEn) begin
			case (req.addr)
				`SPC_ADDR_STATUS: begin
					rd_next[`SPC_ST_ON]    = cmd_reg[`SPC_CMD_ON];
					rd_next[`SPC_ST_FAULT] = |hist_reg;
					rd_next[`SPC_ST_MODE_LSB +: 2] = regMode;
					rd_next[`SPC_ST_HIST_LSB +: 4] = hist_reg;
				end
				`SPC_ADDR_VMEAS_HI: rd_next = measured.volt[31:16];
				`SPC_ADDR_VMEAS_LO: rd_next = measured.volt[15:0];
				`SPC_ADDR_AMEAS_HI: rd_next = measured.amp[31:16];
				`SPC_ADDR_AMEAS_LO: rd_next = measured.amp[15:0];
				`SPC_ADDR_WMEAS_HI: rd_next = measured.watt[31:16];
				`SPC_ADDR_WMEAS_LO: rd_next = measured.watt[15:0];
				default:            rd_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_reg  <= 16'h0000;
			rdv_reg <= 1'b0;
		end else begin
			rd_reg  <= rd_next;
			rdv_reg <= rdv_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ---------------------------------------------------------------
	assign rdData            = rd_reg;
	assign rdValid           = rdv_reg;
	assign targets           = {sp_reg[0], sp_reg[1], sp_reg[2]};
	assign powerStageEn      = cmd_reg[`SPC_CMD_ON];
	assign farSenseOff       = cmd_reg[`SPC_CMD_FAR_SENSE];
	assign analogCurrentMode = cmd_reg[`SPC_CMD_ANALOG_CUR];
	assign floatMode         = cmd_reg[`SPC_CMD_FLOAT];
	assign faultActive       = fault_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_onWrite;
		@(posedge ref_clk) disable iff (!nrst)
		req.wrEn && req.addr == `SPC_ADDR_CMD |=> powerStageEn == $past(req.data[`SPC_CMD_ON]);
	endproperty
	a_onWrite: assert property (p_onWrite) else $error("output enable not taken");

	property p_onHold;
		@(posedge ref_clk) disable iff (!nrst)
		!(req.wrEn && req.addr == `SPC_ADDR_CMD) |=> $stable(powerStageEn);
	endproperty
	a_onHold: assert property (p_onHold) else $error("output enable moved");

	property p_clearSelf;
		@(posedge ref_clk) disable iff (!nrst)
		clearPulse |=> !clearPulse;
	endproperty
	a_clearSelf: assert property (p_clearSelf) else $error("fault clear stuck");

	property p_clearWipes;
		@(posedge ref_clk) disable iff (!nrst)
		clearPulse && !outImpBad && !cableImpBad && !extFault && !idleHit_reg
			|=> !faultActive;
	endproperty
	a_clearWipes: assert property (p_clearWipes) else $error("history survived clear");

	property p_cableGate;
		@(posedge ref_clk) disable iff (!nrst)
		farSenseOff && !clearPulse |=> hist_reg.cableImp == $past(hist_reg.cableImp);
	endproperty
	a_cableGate: assert property (p_cableGate) else $error("cable monitor active");

	property p_impFault;
		@(posedge ref_clk) disable iff (!nrst)
		cmd_reg[`SPC_CMD_IMP_WATCH] && outImpBad |=> hist_reg.outImp && faultActive;
	endproperty
	a_impFault: assert property (p_impFault) else $error("impedance fault lost");

	property p_halfNoEffect;
		@(posedge ref_clk) disable iff (!nrst)
		cmd_reg[`SPC_CMD_DIGITAL] && req.wrEn && req.addr == `SPC_ADDR_VOLT_HI
			&& !loSeen_reg[0] |=> $stable(targets.volt);
	endproperty
	a_halfNoEffect: assert property (p_halfNoEffect) else $error("torn setpoint");

	property p_clampQ15;
		@(posedge ref_clk) disable iff (!nrst)
		cmd_reg[`SPC_CMD_DIGITAL] && !floatMode |=>
			$signed(targets.volt) <= $signed(VOLT_MAX_Q15) || $stable(targets.volt);
	endproperty
	a_clampQ15: assert property (p_clampQ15) else $error("voltage above limit");

	property p_analogTrack;
		@(posedge ref_clk) disable iff (!nrst)
		!cmd_reg[`SPC_CMD_DIGITAL] |=> targets.amp == $past(analogTargets.amp);
	endproperty
	a_analogTrack: assert property (p_analogTrack) else $error("analog not tracked");

	property p_readMeas;
		@(posedge ref_clk) disable iff (!nrst)
		req.rdEn && req.addr == `SPC_ADDR_WMEAS_HI |=> rdValid && rdData == $past(measured.watt[31:16]);
	endproperty
	a_readMeas: assert property (p_readMeas) else $error("power readback wrong");

	// Read, command and link watch checks
	property p_statusRead;
		@(posedge ref_clk) disable iff (!nrst)
		req.rdEn && req.addr == `SPC_ADDR_STATUS |=> rdValid
			&& rdData[`SPC_ST_ON] == $past(powerStageEn)
			&& rdData[`SPC_ST_FAULT] == $past(faultActive);
	endproperty
	a_statusRead: assert property (p_statusRead) else $error("status readback wrong");

	property p_cmdMask;
		@(posedge ref_clk) disable iff (!nrst)
		req.wrEn && req.addr == `SPC_ADDR_CMD |=> cmd_reg[15:`SPC_CMD_BITS] == 4'h0;
	endproperty
	a_cmdMask: assert property (p_cmdMask) else $error("unused command bits stored");

	property p_idleFault;
		@(posedge ref_clk) disable iff (!nrst)
		idleHit_reg |=> hist_reg.linkIdle && faultActive;
	endproperty
	a_idleFault: assert property (p_idleFault) else $error("idle fault lost");

	property p_watchOff;
		@(posedge ref_clk) disable iff (!nrst)
		!cmd_reg[`SPC_CMD_LINK_WATCH] |=> idle_reg == 32'h00000000 && !idleHit_reg;
	endproperty
	a_watchOff: assert property (p_watchOff) else $error("idle count ran while off");

	// Negative floats sit below every limit, so only positives are bounded
	property p_clampFlt;
		@(posedge ref_clk) disable iff (!nrst)
		cmd_reg[`SPC_CMD_DIGITAL] && floatMode |=>
			targets.volt[31] || targets.volt <= VOLT_MAX_FLT || $stable(targets.volt);
	endproperty
	a_clampFlt: assert property (p_clampFlt) else $error("float voltage above limit");

	// Main scenarios; the bench reaches all but c_pairCommit, as it never writes the power pair in float mode

	c_onCycle: cover property (@(posedge ref_clk) disable iff (!nrst)
		powerStageEn ##[1:20] !powerStageEn);
	c_idleFault: cover property (@(posedge ref_clk) disable iff (!nrst)
		$rose(hist_reg.linkIdle));
	c_pairCommit: cover property (@(posedge ref_clk) disable iff (!nrst)
		floatMode && $changed(targets.watt));
	c_halfStaged: cover property (@(posedge ref_clk) disable iff (!nrst)
		hiSeen_reg[1] && !loSeen_reg[1]);
endmodule

// ### spc_register_bank_test.sv
`timescale 1ns/10ps
`include "spc_params.svh"
module spc_register_bank_test;
	localparam int IDLE = 20;
	logic                 ref_clk;
	logic                 nrst;
	spc_pkg::spc_req_t    req;
	logic [15:0]          rdData;
	logic                 rdValid;
	spc_pkg::spc_triple_t analogTargets;
	spc_pkg::spc_triple_t measured;
	spc_pkg::spc_triple_t targets;
	logic [1:0]           regMode;
	logic                 outImpBad;
	logic                 cableImpBad;
	logic                 extFault;
	logic                 powerStageEn;
	logic                 farSenseOff;
	logic                 analogCurrentMode;
	logic                 floatMode;
	logic                 faultActive;
	logic [15:0]          rv;
	logic                 ok;
	logic [15:0]          meas16 [6];
	int                   i;
	int                   miscompares;
	int                   nChecks;

	// Short link idle limit keeps the run brief
	spc_register_bank #(.IDLE_CYCLES(IDLE)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .req(req), .rdData(rdData), .rdValid(rdValid),
		.analogTargets(analogTargets), .measured(measured), .regMode(regMode),
		.outImpBad(outImpBad), .cableImpBad(cableImpBad), .extFault(extFault),
		.targets(targets), .powerStageEn(powerStageEn), .farSenseOff(farSenseOff),
		.analogCurrentMode(analogCurrentMode), .floatMode(floatMode),
		.faultActive(faultActive));
	spc_host_model host (.ref_clk(ref_clk), .req(req), .rdData(rdData), .rdValid(rdValid));

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// Checking helpers
	// ---------------------------------------------------------------
	task automatic results();
		$display("checks %0d miscompares %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask
	// A read that never answers ends the run
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		host.rd(a, rv, ok);
		if (!ok) begin
			miscompares++;
			$display("Error at %0t: no read answer", $time);
			results();
		end
		chk_word({16'h0000, rv}, {16'h0000, exp});
	endtask
	task automatic settle();
		repeat (2) @(negedge ref_clk);
	endtask
	function automatic logic [15:0] st(input logic on, input logic f, input logic [3:0] h);
		return {8'h00, h, regMode, f, on};
	endfunction

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		analogTargets = {32'h00002000, 32'h00003000, 32'h00004000};
		measured = {32'h12345678, 32'h9abcdef0, 32'h02468ace};
		regMode = 2'h2;
		outImpBad = 1'b0;
		cableImpBad = 1'b0;
		extFault = 1'b0;
		miscompares = 0;
		nChecks = 0;
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		chk_bit(powerStageEn, 1'b0);
		rdchk(`SPC_ADDR_STATUS, st(1'b0, 1'b0, 4'h0));
		host.wr(`SPC_ADDR_CMD, 16'h0042);
		settle();
		chk_bit(powerStageEn, 1'b1);
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b0, 4'h0));
		host.wr(`SPC_ADDR_CMD, 16'h004c);
		settle();
		chk_bit(powerStageEn, 1'b0);
		chk_bit(farSenseOff, 1'b1);
		chk_bit(analogCurrentMode, 1'b1);
		host.wr(`SPC_ADDR_CMD, 16'h0042);
		// Low half alone must not move the committed value
		host.wr(`SPC_ADDR_VOLT_LO, 16'h6000);
		settle();
		chk_word(targets.volt, 32'h00000000);
		host.wr(`SPC_ADDR_VOLT_HI, 16'h0000);
		settle();
		chk_word(targets.volt, host.q15(0.75));
		host.wr32(`SPC_ADDR_AMP_HI, host.q15(0.5));
		settle();
		chk_word(targets.amp, 32'h00004000);
		host.wr32(`SPC_ADDR_WATT_HI, 32'h00012345);
		settle();
		chk_word(targets.watt, `SPC_Q15_FULL);
		host.wr(`SPC_ADDR_CMD, 16'h00c2);
		settle();
		chk_bit(floatMode, 1'b1);
		host.wr32(`SPC_ADDR_VOLT_HI, 32'h41f00000);
		settle();
		chk_word(targets.volt, 32'h41f00000);
		host.wr32(`SPC_ADDR_VOLT_HI, 32'h42c80000);
		settle();
		chk_word(targets.volt, `SPC_VOLT_MAX_FLT);
		// Measurement pairs, high half first, then an unmapped address
		meas16 = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0246, 16'h8ace};
		for (i = 0; i < 6; i++) begin
			rdchk(4'(`SPC_ADDR_VMEAS_HI + i), meas16[i]);
		end
		rdchk(4'h9, 16'h0000);
		// Impedance faults, far sense masking and fault clear
		host.wr(`SPC_ADDR_CMD, 16'h00d2);
		outImpBad = 1'b1;
		settle();
		outImpBad = 1'b0;
		chk_bit(faultActive, 1'b1);
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b1, 4'h1));
		host.wr(`SPC_ADDR_CMD, 16'h00d6);
		cableImpBad = 1'b1;
		settle();
		cableImpBad = 1'b0;
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b1, 4'h1));
		// Far sense back on: the cable monitor reports again
		host.wr(`SPC_ADDR_CMD, 16'h00d2);
		cableImpBad = 1'b1;
		settle();
		cableImpBad = 1'b0;
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b1, 4'h3));
		host.wr(`SPC_ADDR_CMD, 16'h00d7);
		settle();
		chk_bit(faultActive, 1'b0);
		extFault = 1'b1;
		@(negedge ref_clk);
		extFault = 1'b0;
		settle();
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b1, 4'h8));
		// Same write again only clears if the bit returned to zero by itself
		host.wr(`SPC_ADDR_CMD, 16'h00d7);
		settle();
		chk_bit(faultActive, 1'b0);
		// Link inactivity watch
		host.wr(`SPC_ADDR_CMD, 16'h0062);
		chk_bit(faultActive, 1'b0);
		for (i = 0; i < IDLE + 10 && faultActive !== 1'b1; i++) begin
			@(negedge ref_clk);
		end
		chk_bit(faultActive, 1'b1);
		if (faultActive !== 1'b1) begin
			results();
		end
		rdchk(`SPC_ADDR_STATUS, st(1'b1, 1'b1, 4'h4));
		host.wr(`SPC_ADDR_CMD, 16'h0043);
		// Analog programming: targets follow inputs, writes ignored
		host.wr(`SPC_ADDR_CMD, 16'h0002);
		settle();
		chk_word(targets.volt, 32'h00002000);
		host.wr32(`SPC_ADDR_AMP_HI, host.q15(0.25));
		settle();
		chk_word(targets.amp, 32'h00003000);
		chk_word(targets.watt, 32'h00004000);
		results();
	end
endmodule
